// ---- logic/kp_defines.svh ----
`ifndef KP_DEFINES_SVH
`define KP_DEFINES_SVH

// ****************************************************
// timing
// ****************************************************
`define CLK_PERIOD_PS 8000
`define TICK_US 1000
`define TICK_CYCLES (`TICK_US * 1000000 / `CLK_PERIOD_PS)
// the following are counted in 1 ms ticks
`define UNLOCK_WIN_MS 16'h7530
`define LONG_HOLD_MS 12'hBB8
`define CLICK_GAP_MS 10'h190
`define FLASH_MS 16'h012C
`define RED_SHOW_MS 16'h0258
`define BLINK_HALF_MS 10'h1F4
`define FLICK_HALF_MS 10'h064

// ****************************************************
// pin layout
// ****************************************************
`define PIN_MIN_LEN 4'h8
`define PIN_MAX_LEN 4'hF
`define PIN_DIG_W 60
`define DIGIT_W 4
`define NUM_DIGITS 10

`endif

// ---- logic/kp_pkg.sv ----
`include "kp_defines.svh"

package kp_pkg;

  typedef struct packed {
    logic [`DIGIT_W-1:0] len;
    logic [`PIN_DIG_W-1:0] dig;
  } pin_t;

  typedef struct packed {
    logic r;
    logic g;
    logic b;
  } led_t;

  typedef enum logic [3:0] {
    ST_LOCKED, ST_FLASH, ST_ADM_ENTRY, ST_RED_ADM, ST_USER_UNL, ST_NEWADM1, ST_NEWADM2,
    ST_RED_USR, ST_ADMIN, ST_NEWUSR1, ST_NEWUSR2, ST_RED_OFF, ST_USB
  } state_t;

endpackage : kp_pkg

// ---- logic/keypad_pin_admin_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "kp_defines.svh"

// What this block does
// - admin PIN may be created from user mode only when none is stored.
// - correct user PIN unlocks; green shows steady.
// - hold 1 and double-click in user mode starts admin entry; red and blue flicker.
// - new admin PIN must have 8 to 15 digits; other lengths rejected.
// - double-click after first admin entry moves to confirm; green blinks.
// - confirmed admin PIN shows steady red then steady green.
// - hold 1 and click once when locked; all flash, then red and green flicker.
// - correct admin PIN and one click show steady red then flickering green.
// - admin unlock of a locked drive erases the user PIN.
// - unlocked drive must reach USB within 30 seconds or it locks again.
// - holding key 3 seconds while unlocked and off USB locks at once.
// - while unlocked on USB all keypad input is ignored.
// - double-click in admin mode starts user PIN entry; blue blinks.
// - new user PIN must have 8 to 15 digits; other lengths rejected.
// - double-click after first user entry gives blinking green for re-entry.
// - confirmed user PIN shows red briefly, then all LEDs off.
// - a PIN of one repeated digit is rejected.
// - a PIN of consecutive digits, up or down, wrapping 9-0, is rejected.
module keypad_pin_admin_sequencer import kp_pkg::*; #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`NUM_DIGITS-1:0] digit_btn,
  input wire logic key_btn,
  input wire logic usb_attached,
  output logic led_red,
  output logic led_green,
  output logic led_blue,
  output logic unlocked
);

  // ****************************************************
  // millisecond tick
  // ****************************************************
  logic [16:0] div_reg;
  wire logic ms_tick;
  assign ms_tick = (div_reg == 17'(TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) div_reg <= 17'h0;
    else div_reg <= ms_tick ? 17'h0 : div_reg + 17'h1;
  end

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [11:0] s1_reg, s2_reg, s3_reg, in_reg, prev_reg;
  wire logic [11:0] raw_in, agree, in_next;
  assign raw_in = {usb_attached, key_btn, digit_btn};
  // a level is taken only once the second and third stages agree
  assign agree = ~(s2_reg ^ s3_reg);
  assign in_next = (agree & s3_reg) | (~agree & in_reg);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 12'h0;
      s2_reg <= 12'h0;
      s3_reg <= 12'h0;
      in_reg <= 12'h0;
      prev_reg <= 12'h0;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      in_reg <= in_next;
      prev_reg <= in_reg;
    end
  end

  wire logic key_lvl, usb_lvl, key_rise, key_fall;
  wire logic [`NUM_DIGITS-1:0] dig_rise;
  assign key_lvl = in_reg[10];
  assign usb_lvl = in_reg[11];
  assign key_rise = in_reg[10] & ~prev_reg[10];
  assign key_fall = ~in_reg[10] & prev_reg[10];
  assign dig_rise = in_reg[9:0] & ~prev_reg[9:0];

  // ****************************************************
  // key clicks and long hold
  // ****************************************************
  logic [11:0] hold_ms;
  logic long_flag, with1_reg;
  logic [1:0] click_cnt;
  logic [9:0] gap_ms;
  wire logic long_hold, click_done, ev_single, ev_double;
  assign long_hold = key_lvl && !key_rise && ms_tick && (hold_ms == `LONG_HOLD_MS - 12'h1);
  assign click_done = (click_cnt != 2'h0) && !key_lvl && (gap_ms == `CLICK_GAP_MS);
  assign ev_single = click_done && (click_cnt == 2'h1);
  assign ev_double = click_done && (click_cnt == 2'h2);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_ms <= 12'h0;
      long_flag <= 1'b0;
    end else begin
      if (key_rise) hold_ms <= 12'h0;
      else if (key_lvl && ms_tick && hold_ms != 12'hFFF) hold_ms <= hold_ms + 12'h1;
      if (key_rise) long_flag <= 1'b0;
      else if (long_hold) long_flag <= 1'b1;
    end
  end

  // a release that ends a long hold is not a click
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      click_cnt <= 2'h0;
      gap_ms <= 10'h0;
      with1_reg <= 1'b0;
    end else begin
      if (key_rise && click_cnt == 2'h0) with1_reg <= in_reg[1];
      if (click_done) click_cnt <= 2'h0;
      else if (key_fall && !long_flag && click_cnt != 2'h3) click_cnt <= click_cnt + 2'h1;
      if (key_fall) gap_ms <= 10'h0;
      else if (click_cnt != 2'h0 && !key_lvl && ms_tick) gap_ms <= gap_ms + 10'h1;
    end
  end

  // ****************************************************
  // digit entry and pattern checks
  // ****************************************************
  logic [`DIGIT_W-1:0] dig_val;
  logic dig_any;
  always_comb begin
    dig_val = 4'h0;
    dig_any = (|dig_rise) && !key_lvl;
    for (int i = `NUM_DIGITS - 1; i >= 0; i--) begin
      if (dig_rise[i]) dig_val = 4'(i);
    end
  end

  state_t state_reg, state_next;
  pin_t ent_reg, cand_reg, user_reg, admin_reg;
  logic rep_reg, asc_reg, desc_reg, ovf_reg, user_ok, admin_ok;
  logic [`DIGIT_W-1:0] last_reg;
  wire logic ent_clear, pin_valid;
  wire logic [`DIGIT_W-1:0] nxt_up, nxt_dn;
  assign ent_clear = click_done || (state_next != state_reg);
  assign nxt_up = (last_reg == 4'h9) ? 4'h0 : last_reg + 4'h1;
  assign nxt_dn = (last_reg == 4'h0) ? 4'h9 : last_reg - 4'h1;
  assign pin_valid = !ovf_reg && (ent_reg.len >= `PIN_MIN_LEN)
                     && !rep_reg && !asc_reg && !desc_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ent_reg <= '0;
      ovf_reg <= 1'b0;
      rep_reg <= 1'b1;
      asc_reg <= 1'b1;
      desc_reg <= 1'b1;
      last_reg <= 4'h0;
    end else if (ent_clear) begin
      ent_reg <= '0;
      ovf_reg <= 1'b0;
    end else if (dig_any) begin
      if (ent_reg.len == `PIN_MAX_LEN) ovf_reg <= 1'b1;
      else ent_reg <= '{len: ent_reg.len + 4'h1, dig: {ent_reg.dig[55:0], dig_val}};
      rep_reg <= (ent_reg.len == 4'h0) || (rep_reg && dig_val == last_reg);
      asc_reg <= (ent_reg.len == 4'h0) || (asc_reg && dig_val == nxt_up);
      desc_reg <= (ent_reg.len == 4'h0) || (desc_reg && dig_val == nxt_dn);
      last_reg <= dig_val;
    end
  end

  // ****************************************************
  // sequencer
  // ****************************************************
  logic [15:0] st_ms, win_ms;
  wire logic unl_state, win_over, red_done, adm_match, usr_match, cand_match;
  assign unl_state = state_reg inside {ST_USER_UNL, ST_NEWADM1, ST_NEWADM2, ST_RED_USR,
                                       ST_RED_ADM, ST_ADMIN, ST_NEWUSR1, ST_NEWUSR2};
  assign win_over = win_ms >= `UNLOCK_WIN_MS;
  assign red_done = st_ms >= `RED_SHOW_MS;
  assign adm_match = admin_ok && (ent_reg == admin_reg);
  assign usr_match = user_ok ? (ent_reg == user_reg) : (!admin_ok && ent_reg.len == 4'h0);
  assign cand_match = (ent_reg == cand_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_LOCKED: if (ev_single && with1_reg && admin_ok) state_next = ST_FLASH;
        else if (ev_single && !with1_reg && usr_match) state_next = ST_USER_UNL;
      ST_FLASH: if (st_ms >= `FLASH_MS) state_next = ST_ADM_ENTRY;
      ST_ADM_ENTRY: if (ev_single) state_next = adm_match ? ST_RED_ADM : ST_LOCKED;
      ST_RED_ADM: if (red_done) state_next = ST_ADMIN;
      ST_USER_UNL: if (ev_double && with1_reg && !admin_ok) state_next = ST_NEWADM1;
      ST_NEWADM1: if (ev_double) state_next = pin_valid ? ST_NEWADM2 : ST_USER_UNL;
      ST_NEWADM2: if (ev_double) state_next = cand_match ? ST_RED_USR : ST_USER_UNL;
      ST_RED_USR: if (red_done) state_next = ST_USER_UNL;
      ST_ADMIN: if (ev_double && !with1_reg) state_next = ST_NEWUSR1;
      ST_NEWUSR1: if (ev_double) state_next = pin_valid ? ST_NEWUSR2 : ST_ADMIN;
      ST_NEWUSR2: if (ev_double) state_next = cand_match ? ST_RED_OFF : ST_ADMIN;
      ST_RED_OFF: if (red_done) state_next = ST_LOCKED;
      ST_USB: if (!usb_lvl) state_next = ST_LOCKED;
      default: state_next = ST_LOCKED;
    endcase
    // usb, long hold and the window override any keypad step
    if (unl_state) begin
      if (usb_lvl) state_next = ST_USB;
      else if (long_hold || win_over) state_next = ST_LOCKED;
    end
  end

  wire logic adm_wr, usr_wr, usr_erase, cand_wr;
  assign adm_wr = (state_reg == ST_NEWADM2) && (state_next == ST_RED_USR);
  assign usr_wr = (state_reg == ST_NEWUSR2) && (state_next == ST_RED_OFF);
  assign usr_erase = (state_reg == ST_ADM_ENTRY) && (state_next == ST_RED_ADM);
  assign cand_wr = (state_next == ST_NEWADM2 && state_reg == ST_NEWADM1)
                   || (state_next == ST_NEWUSR2 && state_reg == ST_NEWUSR1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) state_reg <= ST_LOCKED;
    else state_reg <= state_next;
  end

  // stored PINs change only on a confirmed match, except the user PIN, which is erased on admin unlock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cand_reg <= '0;
      user_reg <= '0;
      admin_reg <= '0;
      user_ok <= 1'b0;
      admin_ok <= 1'b0;
    end else begin
      if (cand_wr) cand_reg <= ent_reg;
      if (adm_wr) begin
        admin_reg <= ent_reg;
        admin_ok <= 1'b1;
      end
      if (usr_erase) begin
        user_reg <= '0;
        user_ok <= 1'b0;
      end else if (usr_wr) begin
        user_reg <= ent_reg;
        user_ok <= 1'b1;
      end
    end
  end

  // st_ms: time in state; win_ms: time since unlock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ms <= 16'h0;
      win_ms <= 16'h0;
    end else begin
      if (state_next != state_reg) st_ms <= 16'h0;
      else if (ms_tick && st_ms != 16'hFFFF) st_ms <= st_ms + 16'h1;
      if (!unl_state) win_ms <= 16'h0;
      else if (ms_tick && !win_over) win_ms <= win_ms + 16'h1;
    end
  end

  // ****************************************************
  // indicators
  // ****************************************************
  logic [9:0] blink_ms, flick_ms;
  logic blink_reg, flick_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_ms <= 10'h0;
      flick_ms <= 10'h0;
      blink_reg <= 1'b0;
      flick_reg <= 1'b0;
    end else if (ms_tick) begin
      blink_ms <= (blink_ms == `BLINK_HALF_MS) ? 10'h0 : blink_ms + 10'h1;
      flick_ms <= (flick_ms == `FLICK_HALF_MS) ? 10'h0 : flick_ms + 10'h1;
      if (blink_ms == `BLINK_HALF_MS) blink_reg <= ~blink_reg;
      if (flick_ms == `FLICK_HALF_MS) flick_reg <= ~flick_reg;
    end
  end

  led_t led_next;
  always_comb begin
    case (state_reg)
      ST_FLASH: led_next = '{r: 1'b1, g: 1'b1, b: 1'b1};
      ST_ADM_ENTRY: led_next = '{r: flick_reg, g: flick_reg, b: 1'b0};
      ST_RED_ADM, ST_RED_USR, ST_RED_OFF: led_next = '{r: 1'b1, g: 1'b0, b: 1'b0};
      ST_USER_UNL, ST_USB: led_next = '{r: 1'b0, g: 1'b1, b: 1'b0};
      ST_NEWADM1: led_next = '{r: flick_reg, g: 1'b0, b: flick_reg};
      ST_NEWADM2, ST_NEWUSR2: led_next = '{r: 1'b0, g: blink_reg, b: 1'b0};
      ST_ADMIN: led_next = '{r: 1'b0, g: flick_reg, b: 1'b0};
      ST_NEWUSR1: led_next = '{r: 1'b0, g: 1'b0, b: blink_reg};
      default: led_next = '{r: 1'b0, g: 1'b0, b: 1'b0};
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      led_red <= 1'b0;
      led_green <= 1'b0;
      led_blue <= 1'b0;
      unlocked <= 1'b0;
    end else begin
      led_red <= led_next.r;
      led_green <= led_next.g;
      led_blue <= led_next.b;
      unlocked <= unl_state || (state_reg == ST_USB);
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence adm_first_ok;
    state_reg == ST_NEWADM1 && ev_double && pin_valid && !usb_lvl && !win_over && !long_hold;
  endsequence
  sequence user_unlock_enter;
    state_reg == ST_LOCKED ##1 state_reg == ST_USER_UNL;
  endsequence
  a_admin_gate: assert property (state_reg == ST_USER_UNL ##1 state_reg == ST_NEWADM1
    |-> !admin_ok) else $error("admin entry begun with admin pin present");
  a_user_green: assert property (user_unlock_enter ##0 !usb_lvl
    |=> led_green && !led_red && !led_blue) else $error("user unlock not steady green");
  a_adm_flicker: assert property (state_reg == ST_NEWADM1 |=> led_red == led_blue)
    else $error("red and blue not together");
  a_len_reject: assert property (state_reg == ST_NEWADM1 && ev_double && !usb_lvl
    && !win_over && ent_reg.len < `PIN_MIN_LEN |=> state_reg == ST_USER_UNL)
    else $error("short pin taken");
  a_confirm_step: assert property (adm_first_ok |=> state_reg == ST_NEWADM2 ##1 !led_red)
    else $error("no confirm step");
  a_flash_all: assert property ($rose(state_reg == ST_FLASH)
    |=> led_red && led_green && led_blue) else $error("no flash of all leds");
  a_user_erase: assert property (state_reg == ST_RED_ADM |-> !user_ok)
    else $error("user pin kept after admin unlock");
  a_usb_ignore: assert property (state_reg == ST_USB && usb_lvl |=> state_reg == ST_USB)
    else $error("keypad acted while on usb");
  a_repeat_reject: assert property (state_reg == ST_NEWUSR1 && ev_double && rep_reg
    && !usb_lvl && !win_over |=> state_reg == ST_ADMIN) else $error("repeated pin taken");
endmodule : keypad_pin_admin_sequencer
`default_nettype wire

// ---- bench/keypad_user.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************************
// person at the keypad
// ****************************************************
module keypad_user (
  input wire logic clk,
  output logic [9:0] digit_btn,
  output logic key_btn
);
  initial begin
    digit_btn = 10'h000;
    key_btn = 1'h0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic key_set(input logic v);
    @(posedge clk) key_btn <= v;
  endtask : key_set

  // first digit sits in the top nibble; the key stays up meanwhile
  task automatic enter_pin(input logic [63:0] pin, input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge clk) digit_btn <= 10'h001 << pin[63-4*i -: 4];
      idle(10);
      @(posedge clk) digit_btn <= 10'h000;
      idle(10);
    end
  endtask : enter_pin

  // clicks well inside the gap; digit 1 held across the whole group when asked
  task automatic clicks(input int n, input logic hold1);
    if (hold1) begin
      @(posedge clk) digit_btn <= 10'h002;
      idle(10);
    end
    repeat (n) begin
      key_set(1'h1);
      idle(20);
      key_set(1'h0);
      idle(20);
    end
    @(posedge clk) digit_btn <= 10'h000;
  endtask : clicks
endmodule : keypad_user
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************************
// sequencer bench, one tick per clock
// ****************************************************
module tb;
  localparam int OFF = 0;
  localparam int ON = 1;
  localparam int BLK = 2;
  localparam int FLK = 3;
  localparam int UNL = 0;
  localparam int LIT = 1;
  localparam int ALL = 2;
  localparam logic [63:0] ADM = 64'h1357_2468_0000_0000;
  localparam logic [63:0] USR = 64'h2019_4473_6000_0000;
  logic clk;
  logic rst_b;
  logic usb_attached;
  logic [9:0] digit_btn;
  logic key_btn;
  logic led_red;
  logic led_green;
  logic led_blue;
  logic unlocked;
  int error_cnt = 0;
  int checked = 0;

  keypad_pin_admin_sequencer #(.TICK_CYCLES(1)) i_keypad_pin_admin_sequencer (
    .clk(clk), .rst_b(rst_b), .digit_btn(digit_btn), .key_btn(key_btn),
    .usb_attached(usb_attached), .led_red(led_red), .led_green(led_green),
    .led_blue(led_blue), .unlocked(unlocked));
  keypad_user i_keypad_user (.clk(clk), .digit_btn(digit_btn), .key_btn(key_btn));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (95000) @(posedge clk);
    fail("run hung");
    final_report();
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic fail(input string msg);
    error_cnt++;
    $display("FAIL %0t: %s", $time, msg);
  endtask : fail

  // sel picks what is judged; it is read at the falling edge, once it has settled
  task automatic chk_bit(input int sel, input logic exp, input string what);
    logic got;
    @(negedge clk);
    got = (sel == UNL) ? unlocked : led_red | led_green | led_blue;
    if (sel == ALL) got = got | unlocked;
    checked++;
    if (got !== exp) fail(what);
  endtask : chk_bit

  // classify each colour: blink gives few edges in 1000 cycles, flicker many
  task automatic pat(input int r, input int g, input int b, input int n, input string what);
    logic [2:0] prev;
    logic [2:0] cur;
    int on[3];
    int tg[3];
    int ex[3];
    int got;
    ex = '{r, g, b};
    prev = {led_red, led_green, led_blue};
    repeat (n) begin
      @(negedge clk);
      cur = {led_red, led_green, led_blue};
      for (int i = 0; i < 3; i++) begin
        on[i] += int'(cur[2-i] === 1'h1);
        tg[i] += int'(cur[2-i] !== prev[2-i]);
      end
      prev = cur;
    end
    for (int i = 0; i < 3; i++) begin
      got = on[i] == 0 ? OFF : on[i] == n ? ON : tg[i] <= 4 ? BLK : FLK;
      checked++;
      if (got != ex[i]) fail(what);
    end
  endtask : pat

  task automatic step(input logic [63:0] pin, input int len, input int n, input logic h1);
    i_keypad_user.enter_pin(pin, len);
    i_keypad_user.clicks(n, h1);
    i_keypad_user.idle(410);
  endtask : step

  task automatic bad_admin(input logic [63:0] pin, input int len, input string what);
    step(pin, 0, 2, 1'h1);
    step(pin, len, 2, 1'h0);
    pat(OFF, ON, OFF, 1000, what);
  endtask : bad_admin

  task automatic hold_lock;
    int n = 0;
    i_keypad_user.key_set(1'h1);
    while (unlocked === 1'h1 && n < 3100) begin
      @(negedge clk);
      n++;
    end
    i_keypad_user.key_set(1'h0);
    i_keypad_user.idle(20);
    checked++;
    if (n < 2995 || n > 3015) fail("long hold lock time");
    chk_bit(LIT, 1'h0, "leds after hold");
    if (n >= 3100) final_report();
    else $display("test hold lock done");
  endtask : hold_lock

  task automatic t_reset;
    repeat (9) @(posedge clk);
    chk_bit(ALL, 1'h0, "outputs in reset");
    @(posedge clk) rst_b <= 1'h1;
    chk_bit(ALL, 1'h0, "outputs after reset");
    $display("test reset done");
  endtask : t_reset

  // a blank device with no codes stored opens on a bare click
  task automatic t_user_first;
    step(USR, 0, 1, 1'h0);
    pat(OFF, ON, OFF, 1000, "user unlock green");
    chk_bit(UNL, 1'h1, "user unlock flag");
    $display("test user unlock done");
  endtask : t_user_first

  task automatic t_admin_bad;
    bad_admin(64'h1357_2460_0000_0000, 7, "seven digits taken");
    bad_admin(64'h1357_2468_1357_2468, 16, "sixteen digits taken");
    bad_admin(64'h3333_3333_0000_0000, 8, "repeated digit taken");
    bad_admin(64'h7890_1234_0000_0000, 8, "wrapping run taken");
    bad_admin(64'h8765_4321_0000_0000, 8, "falling run taken");
    $display("test admin refusals done");
  endtask : t_admin_bad

  task automatic t_admin_create;
    step(ADM, 0, 2, 1'h1);
    pat(FLK, OFF, FLK, 1000, "admin entry colours");
    step(ADM, 8, 2, 1'h0);
    pat(OFF, BLK, OFF, 1000, "admin confirm colours");
    step(ADM, 8, 2, 1'h0);
    pat(ON, OFF, OFF, 500, "admin done red");
    i_keypad_user.idle(150);
    pat(OFF, ON, OFF, 1000, "admin done green");
    step(ADM, 0, 2, 1'h1);
    pat(OFF, ON, OFF, 1000, "second admin entry opened");
    $display("test admin create done");
  endtask : t_admin_create

  task automatic t_admin_unlock;
    step(ADM, 0, 1, 1'h1);
    pat(ON, ON, ON, 250, "flash all");
    i_keypad_user.idle(100);
    pat(FLK, FLK, OFF, 1000, "admin code wait");
    step(ADM, 8, 1, 1'h0);
    pat(ON, OFF, OFF, 500, "admin unlock red");
    i_keypad_user.idle(150);
    pat(OFF, FLK, OFF, 1000, "admin mode green");
    chk_bit(UNL, 1'h1, "admin unlock flag");
    $display("test admin unlock done");
  endtask : t_admin_unlock

  task automatic t_user_create;
    step(USR, 0, 2, 1'h0);
    pat(OFF, OFF, BLK, 1000, "user entry blue");
    step(64'h5555_5555_5000_0000, 9, 2, 1'h0);
    pat(OFF, FLK, OFF, 1000, "repeated user code taken");
    step(USR, 0, 2, 1'h0);
    step(USR, 9, 2, 1'h0);
    pat(OFF, BLK, OFF, 1000, "user confirm green");
    step(USR, 9, 2, 1'h0);
    pat(ON, OFF, OFF, 500, "user done red");
    i_keypad_user.idle(150);
    pat(OFF, OFF, OFF, 500, "user done dark");
    chk_bit(UNL, 1'h0, "locked after user create");
    $display("test user create done");
  endtask : t_user_create

  task automatic t_usb;
    step(USR, 9, 1, 1'h0);
    usb_attached <= 1'h1;
    i_keypad_user.idle(20);
    pat(OFF, ON, OFF, 200, "usb green");
    i_keypad_user.key_set(1'h1);
    i_keypad_user.idle(3200);
    i_keypad_user.key_set(1'h0);
    step(ADM, 8, 1, 1'h1);
    chk_bit(UNL, 1'h1, "keypad acted on usb");
    @(posedge clk) usb_attached <= 1'h0;
    i_keypad_user.idle(20);
    chk_bit(UNL, 1'h0, "usb removal lock");
    $display("test usb done");
  endtask : t_usb

  task automatic t_window;
    int n = 0;
    step(USR, 9, 1, 1'h0);
    i_keypad_user.idle(29000);
    chk_bit(UNL, 1'h1, "early window lock");
    while (unlocked === 1'h1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    checked++;
    if (n < 950 || n > 1050) fail("window length");
    if (n >= 2000) final_report();
    else $display("test window done");
  endtask : t_window

  task automatic t_erase;
    t_admin_unlock();
    hold_lock();
    step(USR, 9, 1, 1'h0);
    chk_bit(UNL, 1'h0, "erased user code unlocks");
    $display("test erase done");
  endtask : t_erase

  initial begin
    rst_b = 1'h0;
    usb_attached = 1'h0;
    t_reset();
    t_user_first();
    t_admin_bad();
    t_admin_create();
    hold_lock();
    t_admin_unlock();
    t_user_create();
    t_usb();
    t_window();
    t_erase();
    final_report();
  end
endmodule : tb
`default_nettype wire
